// [hw/ssrc_pkg.sv]
// Package with constants and carrier types for the sleep-state rail control.
package ssrc_pkg;

  localparam int unsigned CLK_FREQ_HZ     = 200_000_000;
  localparam int unsigned DEBOUNCE_MS     = 30;
  // A press must last longer than the debounce time, so one cycle is added.
  localparam int unsigned DEBOUNCE_CYCLES =
    (CLK_FREQ_HZ / 1000) * DEBOUNCE_MS + 1;
  localparam int unsigned SYNC_STAGES     = 3;
  localparam int unsigned SOFT_START_CYCLES = 64;

  localparam logic RESET_OUT_N_VAL  = 1'b0;
  localparam logic BUTTON_OUT_RESET = 1'b1;

  // Pin function choice of the shared general-purpose pin.
  localparam logic FUNC_GPIO    = 1'b0;
  localparam logic FUNC_VSELECT = 1'b1;

  // Raw host-side inputs, all active low.
  typedef struct packed {
    logic deep_idle_sleep_n;
    logic suspend_ram_sleep_n;
    logic hibernate_sleep_n;
    logic platform_reset_n;
    logic power_button_in_n;
    logic thermal_trip_n;
  } ssrc_host_in_s;

  // Rail group enables.
  typedef struct packed {
    logic always_on;
    logic standby;
    logic suspend;
    logic deep_idle;
  } ssrc_rails_s;

  typedef enum logic [1:0] {
    SSRC_OFF   = 2'b00,
    SSRC_RAMP  = 2'b01,
    SSRC_GOOD  = 2'b10
  } ssrc_start_e;

endpackage : ssrc_pkg

// [hw/ssrc_top.sv]
// Sleep-state rail control: input sync, button debounce and rail enables.
// Function
// (RULE_01) Deep-idle input high enables deep-idle rails.
// (RULE_02) Suspend input high enables suspend rails.
// (RULE_03) Hibernate input high enables standby rails.
// (RULE_04) Always-on rails need button held over 30ms.
// (RULE_05) Button output follows only the debounced level.
// (RULE_06) Core power good high after soft start.
// (RULE_07) Resume reset low until soft start done.
// (RULE_08) Platform reset input is active low.
// (RULE_09) Alert pin pulled low while alert pending.
// (RULE_10) Shared pin is GPIO 9 or voltage select.
// (RULE_11) Thermal trip low shuts off all rails.
// (RULE_12) Synchronise all host inputs before use.
module ssrc_top #(
  parameter int unsigned DEBOUNCE_CYCLES   = ssrc_pkg::DEBOUNCE_CYCLES,
  parameter int unsigned SOFT_START_CYCLES = ssrc_pkg::SOFT_START_CYCLES
) (
  input  wire logic                   clock,
  input  wire logic                   nrst,
  input  wire ssrc_pkg::ssrc_host_in_s host_in,
  input  wire logic                   vid_alert_pending,
  input  wire logic                   shared_pin_func,
  input  wire logic                   shared_pin_in,
  input  wire logic                   gpio9_out,
  input  wire logic                   gpio9_oe,
  output logic                        gpio9_in,
  output logic                        shared_pin_out,
  output logic                        shared_pin_oe,
  output logic                        memory_rail_voltage_select,
  output ssrc_pkg::ssrc_rails_s       rails_en,
  output logic                        power_button_out_n,
  output logic                        core_power_good,
  output logic                        resume_reset_n,
  output logic                        platform_reset_active,
  output logic                        vid_alert_n_out,
  output logic                        vid_alert_n_oe
);

  localparam int unsigned NIN = $bits(ssrc_pkg::ssrc_host_in_s) + 1;
  localparam int unsigned DBW = $clog2(DEBOUNCE_CYCLES + 1);
  localparam int unsigned SSW = $clog2(SOFT_START_CYCLES + 1);

  // Counts below these limits leave the counters no room to work.
  if (DEBOUNCE_CYCLES < 2 || SOFT_START_CYCLES < 1) begin : g_bad_counts
    $error("ssrc_top: counts too small");
  end

  // Three-stage synchronisers; a change counts when stages two and three agree.
  logic [NIN-1:0] raw;
  logic [NIN-1:0] s1_q, s2_q, s3_q, s1_d, s2_d, s3_d;
  logic [NIN-1:0] clean_q, clean_d;
  assign raw = {shared_pin_in, host_in};

  always_comb begin
    s1_d    = raw;
    s2_d    = s1_q;
    s3_d    = s2_q;
    clean_d = clean_q;
    for (int i = 0; i < NIN; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        clean_d[i] = s3_q[i];
      end
    end
    if (!nrst) begin
      s1_d    = '1;
      s2_d    = '1;
      s3_d    = '1;
      clean_d = '1;
    end
  end

  always_ff @(posedge clock) begin // RULE_12
    s1_q    <= s1_d;
    s2_q    <= s2_d;
    s3_q    <= s3_d;
    clean_q <= clean_d;
  end

  ssrc_pkg::ssrc_host_in_s hs;
  logic                    pin_sync;
  assign hs       = clean_q[NIN-2:0];
  assign pin_sync = clean_q[NIN-1];

  // Button debounce: the filtered level changes after a stable run.
  logic [DBW-1:0] db_cnt_q, db_cnt_d;
  logic           btn_q, btn_d;
  logic           aon_q, aon_d;
  // Length of the current low run of the button, read by the press check.
  logic [DBW-1:0] low_run_q, low_run_d;

  always_comb begin
    db_cnt_d  = db_cnt_q;
    btn_d     = btn_q;
    aon_d     = aon_q;
    low_run_d = low_run_q;
    if (hs.power_button_in_n) begin
      low_run_d = '0;
    end else if (low_run_q != '1) begin
      low_run_d = low_run_q + DBW'(1);
    end
    if (hs.power_button_in_n == btn_q) begin
      db_cnt_d = '0;
    end else if (db_cnt_q == DBW'(DEBOUNCE_CYCLES - 1)) begin
      db_cnt_d = '0;
      btn_d    = hs.power_button_in_n; // RULE_05
      if (!hs.power_button_in_n) begin
        aon_d = 1'b1; // RULE_04
      end
    end else begin
      db_cnt_d = db_cnt_q + DBW'(1);
    end
    if (!hs.thermal_trip_n) begin
      aon_d = 1'b0; // RULE_11
    end
    if (!nrst) begin
      db_cnt_d  = '0;
      btn_d     = ssrc_pkg::BUTTON_OUT_RESET;
      aon_d     = 1'b0;
      low_run_d = '0;
    end
  end

  always_ff @(posedge clock) begin
    db_cnt_q  <= db_cnt_d;
    btn_q     <= btn_d;
    aon_q     <= aon_d;
    low_run_q <= low_run_d;
  end

  // Rail enables, soft start and the remaining outputs.
  ssrc_pkg::ssrc_rails_s rails_d;
  ssrc_pkg::ssrc_start_e st_q, st_d;
  logic [SSW-1:0]        ss_cnt_q, ss_cnt_d;
  logic                  pg_d, rsm_d, prst_d, alert_d;
  logic                  g9_d, sp_out_d, sp_oe_d, vsel_d, btn_out_d;
  logic                  vsel_q;

  always_comb begin
    rails_d.deep_idle = hs.deep_idle_sleep_n; // RULE_01
    rails_d.suspend   = hs.suspend_ram_sleep_n; // RULE_02
    rails_d.standby   = hs.hibernate_sleep_n; // RULE_03
    rails_d.always_on = aon_q;
    if (!hs.thermal_trip_n) begin
      rails_d = '0; // RULE_11
    end
    st_d     = st_q;
    ss_cnt_d = ss_cnt_q;
    case (st_q)
      ssrc_pkg::SSRC_OFF: begin
        ss_cnt_d = '0;
        if (aon_q) begin
          st_d = ssrc_pkg::SSRC_RAMP;
        end
      end
      ssrc_pkg::SSRC_RAMP: begin
        ss_cnt_d = ss_cnt_q + SSW'(1);
        if (ss_cnt_q == SSW'(SOFT_START_CYCLES - 1)) begin
          st_d = ssrc_pkg::SSRC_GOOD;
        end
      end
      ssrc_pkg::SSRC_GOOD: begin
        ss_cnt_d = '0;
      end
      default: begin
        st_d = ssrc_pkg::SSRC_OFF;
      end
    endcase
    // A trip drops power good in the same cycle as the rails.
    if (!aon_q || !hs.thermal_trip_n) begin // RULE_11
      st_d     = ssrc_pkg::SSRC_OFF;
      ss_cnt_d = '0;
    end
    pg_d      = (st_d == ssrc_pkg::SSRC_GOOD); // RULE_06
    rsm_d     = (st_d == ssrc_pkg::SSRC_GOOD); // RULE_07
    prst_d    = !hs.platform_reset_n; // RULE_08
    alert_d   = vid_alert_pending; // RULE_09
    btn_out_d = btn_q; // RULE_05
    vsel_d    = vsel_q;
    g9_d      = pin_sync;
    sp_out_d  = 1'b0;
    sp_oe_d   = 1'b0;
    if (shared_pin_func == ssrc_pkg::FUNC_VSELECT) begin
      vsel_d = pin_sync; // RULE_10
    end else begin
      sp_out_d = gpio9_out; // RULE_10
      sp_oe_d  = gpio9_oe;
    end
    if (!nrst) begin
      rails_d   = '0;
      st_d      = ssrc_pkg::SSRC_OFF;
      ss_cnt_d  = '0;
      pg_d      = 1'b0;
      rsm_d     = 1'b0;
      prst_d    = 1'b0;
      alert_d   = 1'b0;
      btn_out_d = ssrc_pkg::BUTTON_OUT_RESET;
      vsel_d    = 1'b0;
      g9_d      = 1'b0;
      sp_out_d  = 1'b0;
      sp_oe_d   = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    rails_en                   <= rails_d;
    st_q                       <= st_d;
    ss_cnt_q                   <= ss_cnt_d;
    core_power_good            <= pg_d;
    resume_reset_n             <= rsm_d;
    platform_reset_active      <= prst_d;
    vid_alert_n_oe             <= alert_d;
    power_button_out_n         <= btn_out_d;
    vsel_q                     <= vsel_d;
    memory_rail_voltage_select <= vsel_d;
    gpio9_in                   <= g9_d;
    shared_pin_out             <= sp_out_d;
    shared_pin_oe              <= sp_oe_d;
    // Open-drain alert only ever drives low.
    vid_alert_n_out            <= 1'b0;
  end

  property p_deep_idle;
    @(posedge clock) disable iff (!nrst)
    hs.thermal_trip_n ##1 nrst |-> rails_en.deep_idle == $past(hs.deep_idle_sleep_n);
  endproperty
  a_deep_idle: assert property (p_deep_idle) else $error("deep idle"); // RULE_01

  property p_suspend;
    @(posedge clock) disable iff (!nrst)
    hs.thermal_trip_n ##1 nrst |-> rails_en.suspend == $past(hs.suspend_ram_sleep_n);
  endproperty
  a_suspend: assert property (p_suspend) else $error("suspend"); // RULE_02

  property p_standby;
    @(posedge clock) disable iff (!nrst)
    hs.thermal_trip_n ##1 nrst |-> rails_en.standby == $past(hs.hibernate_sleep_n);
  endproperty
  a_standby: assert property (p_standby) else $error("standby"); // RULE_03

  property p_aon_press;
    @(posedge clock) disable iff (!nrst)
    $rose(aon_q) |->
      !btn_q && $past(low_run_q) >= DBW'(DEBOUNCE_CYCLES - 1);
  endproperty
  a_aon_press: assert property (p_aon_press) else $error("short press"); // RULE_04

  property p_btn_out;
    @(posedge clock) disable iff (!nrst)
    $changed(btn_q) ##1 nrst |-> power_button_out_n == $past(btn_q);
  endproperty
  a_btn_out: assert property (p_btn_out) else $error("button out"); // RULE_05

  property p_pg;
    @(posedge clock) disable iff (!nrst)
    core_power_good |-> resume_reset_n && rails_en.always_on;
  endproperty
  a_pg: assert property (p_pg) else $error("power good"); // RULE_06

  property p_rsm;
    @(posedge clock) disable iff (!nrst)
    $rose(resume_reset_n) |-> $past(st_q) == ssrc_pkg::SSRC_RAMP;
  endproperty
  a_rsm: assert property (p_rsm) else $error("resume reset"); // RULE_07

  property p_therm;
    @(posedge clock) disable iff (!nrst)
    !hs.thermal_trip_n ##1 nrst |-> rails_en == '0;
  endproperty
  a_therm: assert property (p_therm) else $error("thermal"); // RULE_11

endmodule : ssrc_top

// [test/ssrc_host_model.sv]
// Host model that drives the active-low sleep, reset, button and trip levels.
module ssrc_host_model (
  input  wire logic              clock,
  input  wire logic [5:0]        req,
  output ssrc_pkg::ssrc_host_in_s host_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // Levels change only just after an edge, as a real host output would.
  always @(posedge clock) begin
    host_in <= ssrc_pkg::ssrc_host_in_s'(req);
  end
endmodule : ssrc_host_model

// [test/tb_sleep_state_rail_control.sv]
// Self-checking bench for the sleep-state rail control.
module tb_sleep_state_rail_control;
  timeunit 1ns;
  timeprecision 1ps;

  logic                    clock = 1'b0;
  logic                    nrst = 1'b0;
  logic [5:0]              req = 6'h3f;
  logic                    vid = 1'b0;
  logic                    func = 1'b0;
  logic                    pin_in = 1'b0;
  logic                    g_out = 1'b0;
  logic                    g_oe = 1'b0;
  logic                    g_in, sh_out, sh_oe, vsel, btn, pg, rr, pra;
  logic                    al_out, al_oe;
  ssrc_pkg::ssrc_host_in_s host_in;
  ssrc_pkg::ssrc_rails_s   rails;
  int                      fail_count = 0;
  int                      compares = 0;
  logic [6:0]              rows [8] = '{7'h00, 7'h14, 7'h22, 7'h36,
                                        7'h41, 7'h55, 7'h63, 7'h77};
  logic [3:0]              prev;

  initial forever #2.5 clock = ~clock;

  ssrc_host_model i_host (.clock(clock), .req(req), .host_in(host_in));

  ssrc_top #(.DEBOUNCE_CYCLES(20), .SOFT_START_CYCLES(4)) i_dut (
    .clock(clock), .nrst(nrst), .host_in(host_in),
    .vid_alert_pending(vid), .shared_pin_func(func),
    .shared_pin_in(pin_in), .gpio9_out(g_out), .gpio9_oe(g_oe),
    .gpio9_in(g_in), .shared_pin_out(sh_out), .shared_pin_oe(sh_oe),
    .memory_rail_voltage_select(vsel), .rails_en(rails),
    .power_button_out_n(btn), .core_power_good(pg),
    .resume_reset_n(rr), .platform_reset_active(pra),
    .vid_alert_n_out(al_out), .vid_alert_n_oe(al_oe)
  );

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step

  task automatic chk1(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk1

  task automatic chk4(input logic [3:0] got, input logic [3:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk4

  task automatic wrap_up();
    if (fail_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #50000;
    fail_count++;
    wrap_up();
  end

  initial begin
    step(16);
    chk4(rails, 4'h0);
    chk1(pg, 1'b0);
    chk1(rr, 1'b0);
    chk1(btn, 1'b1);
    chk1(al_oe, 1'b0);
    chk1(sh_oe, 1'b0);
    @(posedge clock) nrst <= 1'b1;
    step(8);
    prev = 4'h7;
    foreach (rows[i]) begin
      @(posedge clock) req[5:3] <= rows[i][6:4];
      step(2);
      chk4(rails, prev);
      step(6);
      chk4(rails, rows[i][3:0]);
      prev = rows[i][3:0];
    end
    @(posedge clock) req[1] <= 1'b0;
    step(10);
    @(posedge clock) req[1] <= 1'b1;
    step(40);
    chk1(rails.always_on, 1'b0);
    chk1(btn, 1'b1);
    @(posedge clock) req[1] <= 1'b0;
    step(20);
    chk1(rails.always_on, 1'b0);
    chk1(pg, 1'b0);
    step(10);
    chk1(rails.always_on, 1'b1);
    chk1(btn, 1'b0);
    step(12);
    chk1(pg, 1'b1);
    chk1(rr, 1'b1);
    @(posedge clock) req[1] <= 1'b1;
    step(30);
    chk1(btn, 1'b1);
    @(posedge clock) req[2] <= 1'b0;
    step(8);
    chk1(pra, 1'b1);
    @(posedge clock) req[2] <= 1'b1;
    step(8);
    chk1(pra, 1'b0);
    @(posedge clock) vid <= 1'b1;
    step(3);
    chk1(al_oe, 1'b1);
    chk1(al_out, 1'b0);
    @(posedge clock) vid <= 1'b0;
    step(3);
    chk1(al_oe, 1'b0);
    @(posedge clock) func <= 1'b1;
    pin_in <= 1'b1;
    step(6);
    chk1(vsel, 1'b1);
    chk1(sh_oe, 1'b0);
    @(posedge clock) pin_in <= 1'b0;
    step(6);
    chk1(vsel, 1'b0);
    @(posedge clock) func <= 1'b0;
    g_oe <= 1'b1;
    g_out <= 1'b1;
    pin_in <= 1'b1;
    step(6);
    chk1(sh_oe, 1'b1);
    chk1(sh_out, 1'b1);
    chk1(g_in, 1'b1);
    @(posedge clock) req[0] <= 1'b0;
    step(8);
    chk4(rails, 4'h0);
    chk1(pg, 1'b0);
    @(posedge clock) req[0] <= 1'b1;
    step(8);
    chk4(rails, 4'h7);
    @(posedge clock) nrst <= 1'b0;
    step(4);
    chk4(rails, 4'h0);
    wrap_up();
  end
endmodule : tb_sleep_state_rail_control
